// ### hdl/dfb_defines.vh
`ifndef DFB_DEFINES_VH
`define DFB_DEFINES_VH

// ----------------------------------------------------------------------
// Command/address word layout
// ----------------------------------------------------------------------
`define DFB_CA_WIDTH      48
`define DFB_CA_BYTES      6
`define DFB_CA_RW_BIT     47
`define DFB_CA_TARGET_BIT 46
`define DFB_CA_BURST_BIT  45
`define DFB_CA_HP_LO      16
`define DFB_HP_HI_512     37
`define DFB_HP_HI_256     36
`define DFB_HP_HI_128     35
`define DFB_CA_WORD_HI    2
`define DFB_CA_WORD_LO    0

// ----------------------------------------------------------------------
// Latency configuration
// ----------------------------------------------------------------------
`define DFB_LAT_CODE_HI   7
`define DFB_LAT_CODE_LO   4
`define DFB_LAT_BASE      5'h05
`define DFB_LAT_MAX       5'h10
`define DFB_LAT_CODE_MAX  4'hb
`define DFB_NONVOLATILE_CONFIG_REG_DEFAULT  8'hb0

// ----------------------------------------------------------------------
// Burst geometry in words
// ----------------------------------------------------------------------
`define DFB_PAGE_BITS     4
`define DFB_WRAP_SEL_16B  2'h0
`define DFB_WRAP_SEL_32B  2'h1

`endif

// ### hdl/dfb_sync.v
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Two-flop synchroniser for pins outside the ref_clk domain
// ----------------------------------------------------------------------
module dfb_sync #(
	parameter WIDTH   = 1,
	parameter RST_VAL = 0
) (
	// Clock and reset
	input  wire             ref_clk,
	input  wire             sys_rst,
	// Asynchronous input and synchronised output
	input  wire [WIDTH-1:0] asyncIn,
	output wire [WIDTH-1:0] syncOut
);

	reg [WIDTH-1:0] meta_q;
	reg [WIDTH-1:0] stable_q;

	always @(posedge ref_clk) begin
		if (sys_rst) begin
			meta_q   <= RST_VAL[WIDTH-1:0];
			stable_q <= RST_VAL[WIDTH-1:0];
		end else begin
			meta_q   <= asyncIn;
			stable_q <= meta_q;
		end
	end

	assign syncOut = stable_q;

endmodule // dfb_sync

`default_nettype wire

// ### hdl/dfb_bus_port.v
// Notes on behaviour
// - Three clocks carry six command/address bytes.
// - Upper byte on rising edge, lower falling.
// - Bit 47 set means read, clear write.
// - Bit 46 space select is ignored.
// - Bit 45 chooses wrapped or linear read.
// - Half-page address from bits 37/36/35 to 16.
// - Bits 2-0 select starting word.
// - Writes carry one word, or linear load.
// - Writes go into the command buffer.
// - Array access starts after second command word.
// - After latency, strobe toggles with each byte.
// - Wrapped wraps, linear advances, hybrid wraps once.
// - Linear burst past array end restarts at zero.
// - First page crossing waits latency minus words.
// - Small wraps never cross; 64-byte may wait.
// - Codes 0-11 give 5-16 clocks.
// - Code from config bits 7-4, default 16.
// - Hardware reset reinitialises and floats outputs.
// - Reset output low until timeout after power-on.
// - Interrupt output pulled low on internal event.
`timescale 1ns/1ps
`default_nettype none
`include "dfb_defines.vh"

module dfb_bus_port #(
	parameter HP_HI  = `DFB_HP_HI_512,
	parameter HP_W   = HP_HI - 15,
	parameter ADDR_W = HP_HI - 12,
	parameter POR_W  = 16
) (
	// Clock and reset
	input  wire              ref_clk,
	input  wire              sys_rst,
	// Flash bus pins
	input  wire              csN,
	input  wire              busClockTrue,
	input  wire              busClockComp,
	input  wire [7:0]        dqIn,
	output wire [7:0]        dqOut,
	output wire              dqOeN,
	output wire              readDataStrobe,
	output wire              readDataStrobeOeN,
	input  wire              hwResetN,
	output wire              porResetOutN,
	output wire              porResetOutOeN,
	output wire              intOutN,
	output wire              intOutOeN,
	// Configuration
	input  wire              volatileCfgValid,
	input  wire [7:0]        volatileCfgReg,
	input  wire              nvCfgWrite,
	input  wire [7:0]        nvCfgData,
	output wire [7:0]        nonvolatileConfigReg,
	input  wire              hybridBurst,
	input  wire [1:0]        wrapLenSel,
	input  wire [POR_W-1:0]  porLowCycles,
	// Array read port
	output wire              arrayStart,
	output wire [HP_W-1:0]   arrayHalfPage,
	output wire [ADDR_W-1:0] arrayAddr,
	input  wire [15:0]       arrayData,
	// Command buffer port
	output wire              cmdBufValid,
	output wire [ADDR_W-1:0] cmdBufAddr,
	output wire [15:0]       cmdBufData,
	// Internal events and status
	input  wire              eventPulse,
	input  wire              intClear,
	output wire              deviceReady
);

	// ------------------------------------------------------------------
	// States
	// ------------------------------------------------------------------
	localparam ST_IDLE = 3'h0;
	localparam ST_CA   = 3'h1;
	localparam ST_LAT  = 3'h2;
	localparam ST_RD   = 3'h3;
	localparam ST_WR   = 3'h4;
	localparam ST_END  = 3'h5;

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	wire [7:0] dqS;
	wire [3:0] ctlS;
	wire       csS;
	wire       ckS;
	wire       ckbS;
	wire       rstS;

	dfb_sync #(.WIDTH(4), .RST_VAL(4'h9)) u_syncCtl (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.asyncIn ({csN, busClockTrue, busClockComp, hwResetN}),
		.syncOut (ctlS)
	);

	dfb_sync #(.WIDTH(8), .RST_VAL(8'h00)) u_syncDq (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.asyncIn (dqIn),
		.syncOut (dqS)
	);

	assign csS  = ctlS[3];
	assign ckS  = ctlS[2];
	assign ckbS = ctlS[1];
	assign rstS = ctlS[0];

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	reg [2:0]        state_q;
	reg              csPrev_q;
	reg              ckPrev_q;
	reg [2:0]        byteCnt_q;
	reg [39:0]       caShift_q;
	reg [ADDR_W-1:0] addr_q;
	reg              linear_q;
	reg              hybLin_q;
	reg [4:0]        lat_q;
	reg [4:0]        latCnt_q;
	reg [4:0]        gap_q;
	reg              crossed_q;
	reg [5:0]        words_q;
	reg              wordPend_q;
	reg [7:0]        lowByte_q;
	reg [7:0]        hiByte_q;
	reg [7:0]        dqOut_q;
	reg              dqOeN_q;
	reg              strobe_q;
	reg              strobeOeN_q;
	reg              arrayStart_q;
	reg [HP_W-1:0]   halfPage_q;
	reg              cmdValid_q;
	reg [ADDR_W-1:0] cmdAddr_q;
	reg [15:0]       cmdData_q;
	reg [7:0]        nvCfg_q;
	reg [POR_W-1:0]  porCnt_q;
	reg              porDone_q;
	reg              intPend_q;
	wire             intPend_d;

	// ------------------------------------------------------------------
	// Edge detection and latency decode
	// ------------------------------------------------------------------
	wire       rise     = ckS & ~ckPrev_q;
	wire       fall     = ~ckS & ckPrev_q;
	wire       txStart  = ~csS & csPrev_q & ~ckS & ckbS;
	wire [7:0] cfgSel   = volatileCfgValid ? volatileCfgReg : nvCfg_q;
	wire [3:0] latCode  = cfgSel[`DFB_LAT_CODE_HI:`DFB_LAT_CODE_LO];
	// Reserved codes fall back to the slowest setting, which is always safe.
	wire [4:0] latDec   = (latCode > `DFB_LAT_CODE_MAX) ? `DFB_LAT_MAX :
	                      (`DFB_LAT_BASE + {1'b0, latCode});
	wire [47:0] caFull  = {caShift_q, dqS};
	wire [31:0] caUpper = {caShift_q[23:0], dqS};

	// ------------------------------------------------------------------
	// Next read address
	// ------------------------------------------------------------------
	wire [2:0]        wrapBits  = (wrapLenSel == `DFB_WRAP_SEL_16B) ? 3'h3 :
	                              (wrapLenSel == `DFB_WRAP_SEL_32B) ? 3'h4 : 3'h5;
	wire [5:0]        wrapWords = 6'h01 << wrapBits;
	wire [ADDR_W-1:0] wrapMask  = {{(ADDR_W-6){1'b0}}, wrapWords - 6'h01};
	wire [ADDR_W-1:0] incAddr   = addr_q + {{(ADDR_W-1){1'b0}}, 1'b1};
	wire [ADDR_W-1:0] grpBase   = addr_q & ~wrapMask;
	wire              linMode   = linear_q | hybLin_q;
	wire              hybSwitch = ~linMode & hybridBurst & (words_q + 6'h01 == wrapWords);
	wire [6:0]        wordsNext = {1'b0, words_q} + 7'h01;
	reg  [ADDR_W-1:0] nextAddr;

	always @* begin
		if (linMode) begin
			nextAddr = incAddr;
		end else if (hybSwitch) begin
			nextAddr = grpBase + {{(ADDR_W-6){1'b0}}, wrapWords};
		end else begin
			nextAddr = grpBase | (incAddr & wrapMask);
		end
	end

	wire pageCross = nextAddr[ADDR_W-1:`DFB_PAGE_BITS] != addr_q[ADDR_W-1:`DFB_PAGE_BITS];
	// Only linear flow, the hybrid switch out of a group and the 64-byte wrap can leave the page at all.
	wire gapAllowed = linMode | hybSwitch | (wrapBits == 3'h5);
	wire [4:0] gapCalc = ({2'h0, lat_q} > wordsNext) ? (lat_q - wordsNext[4:0]) : 5'h00;

	// ------------------------------------------------------------------
	// Bus state machine
	// ------------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (sys_rst | ~rstS | ~porDone_q) begin
			state_q      <= ST_IDLE;
			csPrev_q     <= 1'b1;
			ckPrev_q     <= 1'b0;
			byteCnt_q    <= 3'h0;
			caShift_q    <= 40'h0;
			addr_q       <= {ADDR_W{1'b0}};
			linear_q     <= 1'b0;
			hybLin_q     <= 1'b0;
			lat_q        <= `DFB_LAT_MAX;
			latCnt_q     <= 5'h00;
			gap_q        <= 5'h00;
			crossed_q    <= 1'b0;
			words_q      <= 6'h00;
			wordPend_q   <= 1'b0;
			lowByte_q    <= 8'h00;
			hiByte_q     <= 8'h00;
			dqOut_q      <= 8'h00;
			dqOeN_q      <= 1'b1;
			strobe_q     <= 1'b0;
			strobeOeN_q  <= 1'b1;
			arrayStart_q <= 1'b0;
			halfPage_q   <= {HP_W{1'b0}};
			cmdValid_q   <= 1'b0;
			cmdAddr_q    <= {ADDR_W{1'b0}};
			cmdData_q    <= 16'h0000;
		end else begin
			csPrev_q     <= csS;
			ckPrev_q     <= ckS;
			arrayStart_q <= 1'b0;
			cmdValid_q   <= 1'b0;
			if (csS && state_q != ST_IDLE) begin
				// Deselect ends any phase at once and releases the pins.
				state_q     <= ST_IDLE;
				dqOeN_q     <= 1'b1;
				strobeOeN_q <= 1'b1;
				strobe_q    <= 1'b0;
			end else begin
				case (state_q)
				ST_IDLE: begin
					if (txStart) begin
						state_q     <= ST_CA;
						byteCnt_q   <= 3'h0;
						strobe_q    <= 1'b0;
						strobeOeN_q <= 1'b0;
					end
				end
				ST_CA: begin
					if (rise || fall) begin
						caShift_q <= {caShift_q[31:0], dqS};
						byteCnt_q <= byteCnt_q + 3'h1;
						if (byteCnt_q == 3'h3) begin
							halfPage_q   <= caUpper[HP_HI-16:0];
							arrayStart_q <= caUpper[31];
						end
						if (byteCnt_q == 3'h5) begin
							// The space select bit is deliberately not decoded.
							addr_q    <= {caFull[HP_HI:`DFB_CA_HP_LO],
							              caFull[`DFB_CA_WORD_HI:`DFB_CA_WORD_LO]};
							linear_q  <= caFull[`DFB_CA_BURST_BIT];
							hybLin_q  <= 1'b0;
							lat_q     <= latDec;
							latCnt_q  <= 5'h00;
							gap_q     <= 5'h00;
							crossed_q <= 1'b0;
							words_q   <= 6'h00;
							state_q   <= caFull[`DFB_CA_RW_BIT] ? ST_LAT : ST_WR;
						end
					end
				end
				ST_LAT: begin
					if (rise) begin
						if (latCnt_q == lat_q) begin
							dqOut_q    <= arrayData[15:8];
							lowByte_q  <= arrayData[7:0];
							dqOeN_q    <= 1'b0;
							strobe_q   <= 1'b1;
							wordPend_q <= 1'b1;
							state_q    <= ST_RD;
						end else begin
							latCnt_q <= latCnt_q + 5'h01;
						end
					end
				end
				ST_RD: begin
					if (rise) begin
						if (gap_q != 5'h00) begin
							gap_q <= gap_q - 5'h01;
						end else begin
							dqOut_q    <= arrayData[15:8];
							lowByte_q  <= arrayData[7:0];
							strobe_q   <= 1'b1;
							wordPend_q <= 1'b1;
						end
					end else if (fall && wordPend_q) begin
						dqOut_q    <= lowByte_q;
						strobe_q   <= 1'b0;
						wordPend_q <= 1'b0;
						addr_q     <= nextAddr;
						if (hybSwitch) begin
							hybLin_q <= 1'b1;
						end
						if (words_q != 6'h3f) begin
							words_q <= wordsNext[5:0];
						end
						if (pageCross && gapAllowed && !crossed_q) begin
							crossed_q <= 1'b1;
							gap_q     <= gapCalc;
						end
					end
				end
				ST_WR: begin
					if (rise) begin
						hiByte_q <= dqS;
					end else if (fall) begin
						cmdValid_q <= 1'b1;
						cmdAddr_q  <= addr_q;
						cmdData_q  <= {hiByte_q, dqS};
						addr_q     <= incAddr;
					end
				end
				ST_END: begin
					state_q <= ST_IDLE;
				end
				default: begin
					state_q <= ST_IDLE;
				end
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// Configuration, power-on reset output and interrupt
	// ------------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			nvCfg_q <= `DFB_NONVOLATILE_CONFIG_REG_DEFAULT;
		end else if (nvCfgWrite) begin
			nvCfg_q <= nvCfgData;
		end
	end

	// The timeout is read after release so a strap on the port is honoured.
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			porCnt_q  <= {POR_W{1'b0}};
			porDone_q <= 1'b0;
		end else if (!porDone_q) begin
			if (porCnt_q >= porLowCycles) begin
				porDone_q <= 1'b1;
			end else begin
				porCnt_q <= porCnt_q + {{(POR_W-1){1'b0}}, 1'b1};
			end
		end
	end

	// A new event in the clearing cycle keeps the interrupt asserted.
	assign intPend_d = eventPulse | (intPend_q & ~intClear);

	always @(posedge ref_clk) begin
		if (sys_rst | ~rstS) begin
			intPend_q <= 1'b0;
		end else begin
			intPend_q <= intPend_d;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign dqOut                = dqOut_q;
	assign dqOeN                = dqOeN_q;
	assign readDataStrobe       = strobe_q;
	assign readDataStrobeOeN    = strobeOeN_q;
	assign porResetOutN         = 1'b0;
	assign porResetOutOeN       = porDone_q;
	assign intOutN              = 1'b0;
	assign intOutOeN            = ~intPend_q;
	assign nonvolatileConfigReg = nvCfg_q;
	assign arrayStart           = arrayStart_q;
	assign arrayHalfPage        = halfPage_q;
	assign arrayAddr            = addr_q;
	assign cmdBufValid          = cmdValid_q;
	assign cmdBufAddr           = cmdAddr_q;
	assign cmdBufData           = cmdData_q;
	assign deviceReady          = porDone_q;

endmodule // dfb_bus_port

`default_nettype wire

// ### verif/dfb_bus_port_sva.sv
`timescale 1ns/1ps
`default_nettype none

module dfb_bus_port_sva (
	// Clock and reset
	input wire logic       ref_clk,
	input wire logic       sys_rst,
	// Pins
	input wire logic       csN,
	input wire logic       hwResetN,
	input wire logic       dqOeN,
	input wire logic       readDataStrobeOeN,
	input wire logic       porResetOutOeN,
	input wire logic       intOutOeN,
	// Configuration, events and status
	input wire logic       nvCfgWrite,
	input wire logic [7:0] nvCfgData,
	input wire logic [7:0] nonvolatileConfigReg,
	input wire logic       eventPulse,
	input wire logic       intClear,
	input wire logic       cmdBufValid,
	input wire logic       arrayStart,
	input wire logic       deviceReady
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	a_por_hold: assert property ($past(sys_rst) |-> !porResetOutOeN && !deviceReady)
		else $error("reset output not held after reset");
	a_nv_default: assert property ($past(sys_rst) |-> nonvolatileConfigReg == 8'hb0)
		else $error("config default wrong");
	a_nv_write: assert property (nvCfgWrite |=> nonvolatileConfigReg == $past(nvCfgData))
		else $error("config write lost");
	a_int_set: assert property (hwResetN [*4] ##0 eventPulse |=> !intOutOeN)
		else $error("event did not raise interrupt");
	a_int_hold: assert property (hwResetN [*4] ##0 (!intOutOeN && !intClear) |=> !intOutOeN)
		else $error("interrupt dropped without clear");
	a_hw_float: assert property (!hwResetN [*5] |-> dqOeN && readDataStrobeOeN && intOutOeN)
		else $error("pins driven in hardware reset");
	a_idle_float: assert property (csN [*5] |-> dqOeN && readDataStrobeOeN)
		else $error("pins driven while deselected");
	a_drive_pair: assert property (!dqOeN |-> !readDataStrobeOeN)
		else $error("data driven without strobe");
	a_cmd_pulse: assert property (cmdBufValid |=> !cmdBufValid)
		else $error("command buffer pulse too long");
	a_arr_once: assert property (arrayStart |=> !arrayStart [*8])
		else $error("array access restarted");

	c_write: cover property (cmdBufValid);
	c_read: cover property ($fell(dqOeN));
	c_int: cover property ($fell(intOutOeN));
endmodule // dfb_bus_port_sva

bind dfb_bus_port dfb_bus_port_sva dfb_bus_port_sva_i (
	.ref_clk(ref_clk), .sys_rst(sys_rst), .csN(csN), .hwResetN(hwResetN), .dqOeN(dqOeN),
	.readDataStrobeOeN(readDataStrobeOeN), .porResetOutOeN(porResetOutOeN),
	.intOutOeN(intOutOeN), .nvCfgWrite(nvCfgWrite), .nvCfgData(nvCfgData),
	.nonvolatileConfigReg(nonvolatileConfigReg), .eventPulse(eventPulse),
	.intClear(intClear), .cmdBufValid(cmdBufValid), .arrayStart(arrayStart),
	.deviceReady(deviceReady)
);

`default_nettype wire

// ### verif/dfb_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module dfb_host_model (
	// Host drive
	output logic            csN,
	output logic            busClockTrue,
	output logic            busClockComp,
	output logic [7:0]      hostDq,
	// Resolved bus levels
	input  wire logic [7:0] dqBus,
	input  wire logic       strobe
);
	logic [15:0] rdw [0:15];
	int          first;
	int          gap;

	initial begin
		csN          = 1'b1;
		busClockTrue = 1'b0;
		busClockComp = 1'b1;
		hostDq       = 8'h00;
	end

	// Data settles half an edge ahead so the device samples it centred.
	task automatic edgeOut(input logic [7:0] b);
		hostDq = b;
		#40;
		busClockTrue = ~busClockTrue;
		busClockComp = ~busClockComp;
		#40;
	endtask

	task automatic start(input logic [47:0] ca);
		csN = 1'b0;
		for (int i = 5; i >= 0; i--) begin
			edgeOut(ca[i*8 +: 8]);
		end
	endtask

	// The clock stands low between frames; released lines show no stale value.
	task automatic stop();
		#40;
		csN    = 1'b1;
		hostDq = ~hostDq;
		#160;
	endtask

	task automatic wr(input logic [47:0] ca, input logic [15:0] d);
		start(ca);
		edgeOut(d[15:8]);
		edgeOut(d[7:0]);
		stop();
	endtask

	task automatic rd(input logic [47:0] ca, input int n);
		int   k;
		logic hi;
		k     = 0;
		first = 0;
		gap   = 0;
		start(ca);
		for (int cyc = 3; cyc < 64 && k < n; cyc++) begin
			hostDq       = ~hostDq;
			busClockTrue = 1'b1;
			busClockComp = 1'b0;
			#70;
			hi           = (strobe === 1'b1);
			rdw[k][15:8] = dqBus;
			#10;
			hostDq       = ~hostDq;
			busClockTrue = 1'b0;
			busClockComp = 1'b1;
			#70;
			if (hi) begin
				rdw[k][7:0] = dqBus;
				if (k == 0)
					first = cyc;
				k++;
			end else if (k > 0)
				gap++;
			#10;
		end
		stop();
	endtask
endmodule // dfb_host_model

`default_nettype wire

// ### verif/dfb_bus_port_bench.sv
`timescale 1ns/1ps
`default_nettype none

module dfb_bus_port_bench;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic        ref_clk, sys_rst, csN, busClockTrue, busClockComp, strobe;
	logic        dqOeN, readDataStrobe, readDataStrobeOeN, hwResetN, porResetOutN;
	logic        porResetOutOeN, intOutN, intOutOeN, volatileCfgValid, nvCfgWrite;
	logic        hybridBurst, arrayStart, cmdBufValid, eventPulse, intClear, deviceReady;
	logic [7:0]  hostDq, dqBus, dqOut, volatileCfgReg, nvCfgData, nonvolatileConfigReg;
	logic [1:0]  wrapLenSel;
	logic [21:0] arrayHalfPage;
	logic [24:0] arrayAddr, cmdBufAddr;
	logic [15:0] arrayData, cmdBufData;
	int          badCount, testsRun, nWr, nRd;

	function automatic logic [15:0] dat(input logic [24:0] a);
		return {a[7:0] ^ 8'h5a, a[15:8]};
	endfunction

	function automatic logic [47:0] ca(input logic r, l, input logic [21:0] h, input logic [2:0] w);
		return {r, 1'b0, l, 7'h00, h, 13'h0000, w};
	endfunction

	assign dqBus     = dqOeN ? hostDq : dqOut;
	assign strobe    = readDataStrobeOeN ? hostDq[0] : readDataStrobe;
	assign arrayData = dat(arrayAddr);

	dfb_bus_port dfb_bus_port_i (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .csN(csN), .busClockTrue(busClockTrue),
		.busClockComp(busClockComp), .dqIn(dqBus), .dqOut(dqOut), .dqOeN(dqOeN),
		.readDataStrobe(readDataStrobe), .readDataStrobeOeN(readDataStrobeOeN),
		.hwResetN(hwResetN), .porResetOutN(porResetOutN), .porResetOutOeN(porResetOutOeN),
		.intOutN(intOutN), .intOutOeN(intOutOeN), .volatileCfgValid(volatileCfgValid),
		.volatileCfgReg(volatileCfgReg), .nvCfgWrite(nvCfgWrite), .nvCfgData(nvCfgData),
		.nonvolatileConfigReg(nonvolatileConfigReg), .hybridBurst(hybridBurst),
		.wrapLenSel(wrapLenSel), .porLowCycles(16'h0004), .arrayStart(arrayStart),
		.arrayHalfPage(arrayHalfPage), .arrayAddr(arrayAddr), .arrayData(arrayData),
		.cmdBufValid(cmdBufValid), .cmdBufAddr(cmdBufAddr), .cmdBufData(cmdBufData),
		.eventPulse(eventPulse), .intClear(intClear), .deviceReady(deviceReady)
	);

	dfb_host_model dfb_host_model_i (
		.csN(csN), .busClockTrue(busClockTrue), .busClockComp(busClockComp),
		.hostDq(hostDq), .dqBus(dqBus), .strobe(strobe)
	);

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		if (cmdBufValid === 1'b1)
			nWr++;
		if (arrayStart === 1'b1)
			nRd++;
	end

	// ----------------------------------------------------------------
	// Checking
	// ----------------------------------------------------------------
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		testsRun++;
		if (got !== exp) begin
			badCount++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic printVerdict();
		$display("comparisons %0d mismatches %0d", testsRun, badCount);
		if (badCount == 0 && testsRun > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	// Wrapped groups follow wrapLenSel; hybrid carries on past the group end.
	task automatic rdChk(input logic l, y, input logic [21:0] h, input logic [2:0] w,
		input int n, input int g);
		logic [24:0] a, m;
		m = (wrapLenSel == 2'h0) ? 25'h7 : (wrapLenSel == 2'h1) ? 25'hf : 25'h1f;
		hybridBurst = y;
		dfb_host_model_i.rd(ca(1'b1, l, h, w), n);
		for (int i = 0; i < n; i++) begin
			a = {h, w} + i;
			if (y && !l && i > m)
				a = ({h, w} & ~m) + i;
			else if (!l)
				a = ({h, w} & ~m) | (a & m);
			chk(dfb_host_model_i.rdw[i], dat(a));
		end
		chk(dfb_host_model_i.gap, g);
	endtask

	initial begin
		#400000;
		badCount++;
		printVerdict();
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		{badCount, testsRun, nWr, nRd} = '0;
		sys_rst = 1'b1;
		{hwResetN, volatileCfgValid, nvCfgWrite, nvCfgData} = {1'b1, 1'b0, 1'b0, 8'h30};
		{hybridBurst, eventPulse, intClear, wrapLenSel, volatileCfgReg} = '0;
		tick(2);
		sys_rst = 1'b0;
		chk(porResetOutOeN, 1'b0);
		chk(nonvolatileConfigReg, 8'hb0);
		tick(8);
		chk({deviceReady, porResetOutOeN}, 2'b11);
		$display("test reset done");
		dfb_host_model_i.wr(ca(1'b0, 1'b1, 22'h12345, 3'h6), 16'h2345);
		chk({cmdBufAddr, cmdBufData}, {22'h12345, 3'h6, 16'h2345});
		chk(nWr, 1);
		chk(nRd, 0);
		$display("test write done");
		dfb_host_model_i.rd(ca(1'b1, 1'b0, 22'h1, 3'h0), 1);
		chk(dfb_host_model_i.first, 19);
		nvCfgWrite = 1'b1;
		tick(1);
		nvCfgWrite = 1'b0;
		chk(nonvolatileConfigReg, 8'h30);
		dfb_host_model_i.rd(ca(1'b1, 1'b0, 22'h1, 3'h0), 1);
		chk(dfb_host_model_i.first, 11);
		volatileCfgValid = 1'b1;
		for (int c = 0; c < 16; c++) begin
			volatileCfgReg = {c[3:0], 4'h0};
			dfb_host_model_i.rd(ca(1'b1, 1'b0, 22'h1, 3'h0), 1);
			chk(dfb_host_model_i.first, c > 11 ? 19 : 8 + c);
		end
		$display("test latency done");
		volatileCfgReg = 8'h70;
		rdChk(1'b0, 1'b0, 22'h2, 3'h5, 10, 0);
		rdChk(1'b1, 1'b0, 22'h2, 3'h7, 12, 3);
		rdChk(1'b1, 1'b0, 22'h3fffff, 3'h6, 4, 10);
		chk(arrayHalfPage, 22'h3fffff);
		rdChk(1'b0, 1'b1, 22'h2, 3'h5, 12, 0);
		wrapLenSel = 2'h1;
		rdChk(1'b0, 1'b0, 22'h2, 3'h5, 16, 0);
		wrapLenSel = 2'h2;
		rdChk(1'b0, 1'b0, 22'h2, 3'h7, 12, 3);
		chk(nRd, 24);
		$display("test bursts done");
		eventPulse = 1'b1;
		tick(1);
		eventPulse = 1'b0;
		chk(intOutOeN, 1'b0);
		intClear = 1'b1;
		tick(1);
		intClear = 1'b0;
		chk(intOutOeN, 1'b1);
		{eventPulse, intClear} = 2'b11;
		tick(1);
		chk(intOutOeN, 1'b0);
		chk({porResetOutN, intOutN}, 2'b00);
		{eventPulse, intClear, hwResetN} = 3'b000;
		tick(6);
		chk({intOutOeN, dqOeN, readDataStrobeOeN}, 3'b111);
		hwResetN = 1'b1;
		tick(4);
		$display("test interrupt and reset done");
		printVerdict();
	end
endmodule // dfb_bus_port_bench

`default_nettype wire
